// *** rtl/aux_ctrl_pkg.sv ***
package aux_ctrl_pkg;
  // ************************************************************
  // register map (byte offsets)
  // ************************************************************
  localparam logic [7:0] OFS_BOARD_CONTROL = 8'h00; // control word
  localparam logic [7:0] OFS_PORT = 8'h04;          // digital port
  localparam logic [7:0] OFS_RATE_A = 8'h1C;        // sample divider
  localparam logic [7:0] OFS_RATE_B = 8'h20;        // trigger divider
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h30;  // event status

  // ************************************************************
  // control word fields
  // ************************************************************
  localparam int BIT_RATE_A_EN = 0;       // enable sample divider
  localparam int BIT_RATE_B_EN = 1;       // enable trigger divider
  localparam int BIT_FAST_SAMPLE = 2;     // fast sampling select
  localparam int BIT_CLK_MASTER = 3;      // input clock master
  localparam int BIT_TRIG_MASTER = 4;     // trigger master
  localparam int BIT_CAL_START = 5;       // calibration start
  localparam int BIT_CAL_OK = 6;          // calibration passed (ro)

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int DIV_W = 24;              // divisor width
  localparam int PORT_N = 6;              // port lines
  localparam int PORT_DIR_LSB = 8;        // direction field position
  localparam int EVT_N = 16;              // selection field width
  localparam int EVT_RESP_LSB = 16;       // response field position
  localparam int EVT_CAL_DONE = 0;        // calibration done event
  localparam int EVT_PORT0_RISE = 8;      // port line 0 rising
  localparam int STAT_CAL_BUSY = 15;      // busy flag in reserved slot
  localparam logic [23:0] RATE_A_RST = 24'h00007E;
  localparam logic [23:0] RATE_B_RST = 24'h002760;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 20_000_000;     // board clock rate
  localparam int CAL_LIMIT_S = 10;        // longest calibration time
  localparam longint CAL_LIMIT_CYC = longint'(CAL_LIMIT_S) * CLK_HZ;

  // ************************************************************
  // calibration sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;
endpackage

// *** rtl/board_aux_control_status.sv ***
`timescale 1ns/1ps
module board_aux_control_status
  import aux_ctrl_pkg::*;
#(
  parameter longint CAL_TIMEOUT = CAL_LIMIT_CYC, // calibration cutoff
  parameter int EVT_W = EVT_N                    // event inputs
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic rate_a_tick,
  output logic rate_b_tick,
  output logic fast_sample,
  input wire logic link_clk_in,
  input wire logic link_trig_in,
  input wire logic link_oclk_in,
  input wire logic local_clk,
  input wire logic local_trig,
  input wire logic local_oclk,
  output logic sample_clk,
  output logic sample_trig,
  output logic link_clk_out,
  output logic link_clk_oe,
  output logic link_trig_out,
  output logic link_trig_oe,
  input wire logic oclk_master,
  output logic out_clk,
  input wire logic [5:0] port_line_in,
  output logic [5:0] port_line_out,
  output logic [5:0] port_line_oe,
  output logic cal_run,
  input wire logic cal_engine_done,
  input wire logic cal_engine_fail,
  output logic cal_out_full_scale,
  input wire logic [EVT_W-1:0] event_in
);
  import aux_ctrl_pkg::*;

  // ************************************************************
  // register state
  // ************************************************************
  logic [DIV_W-1:0] rate_a_div_q; // sample divisor
  logic [DIV_W-1:0] rate_b_div_q; // trigger divisor
  logic [DIV_W-1:0] rate_a_cnt_q; // sample counter
  logic [DIV_W-1:0] rate_b_cnt_q; // trigger counter
  logic [7:0] ctrl_q;             // control word writable bits
  logic cal_ok_q;                 // calibration passed
  logic [5:0] port_val_q;         // port value bits
  logic [5:0] port_dir_q;         // port direction bits
  logic [1:0] port_rsv_q;         // reserved rw bits 6..7
  logic [EVT_N-1:0] sel_q;        // event selection
  logic [EVT_N-1:0] resp_q;       // event responses
  logic [EVT_N-1:0] evt_prev_q;   // previous event levels
  logic [EVT_N-1:0] evt_now;      // current event levels
  logic [EVT_N-1:0] evt_rise;     // false-to-true edges
  cal_state_t cal_q;              // calibration sequencer
  logic [63:0] cal_cnt_q;         // calibration elapsed cycles
  logic cal_finish;               // calibration ending now
  logic cal_busy;                 // calibration in progress
  logic wr_ctrl, wr_port, wr_ra, wr_rb, wr_evt;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_BOARD_CONTROL);
  assign wr_port = reg_wr && (reg_addr == OFS_PORT);
  assign wr_ra = reg_wr && (reg_addr == OFS_RATE_A);
  assign wr_rb = reg_wr && (reg_addr == OFS_RATE_B);
  assign wr_evt = reg_wr && (reg_addr == OFS_EVENT_STATUS);

  // ************************************************************
  // rate dividers
  // ************************************************************
  // divisor registers, 24 bits wide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_a_div_q <= RATE_A_RST;
      rate_b_div_q <= RATE_B_RST;
    end else begin
      if (wr_ra) begin
        rate_a_div_q <= reg_wdata[DIV_W-1:0];
      end
      if (wr_rb) begin
        rate_b_div_q <= reg_wdata[DIV_W-1:0];
      end
    end
  end

  // counters: one tick per divisor cycles, held idle when disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_a_cnt_q <= '0;
      rate_a_tick <= 1'b0;
    end else if (!ctrl_q[BIT_RATE_A_EN]) begin
      rate_a_cnt_q <= '0;
      rate_a_tick <= 1'b0;
    end else if (rate_a_cnt_q + 24'h000001 >= rate_a_div_q) begin
      rate_a_cnt_q <= '0;
      rate_a_tick <= 1'b1;
    end else begin
      rate_a_cnt_q <= rate_a_cnt_q + 24'h000001;
      rate_a_tick <= 1'b0;
    end
  end

  // second divider, same structure
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_b_cnt_q <= '0;
      rate_b_tick <= 1'b0;
    end else if (!ctrl_q[BIT_RATE_B_EN]) begin
      rate_b_cnt_q <= '0;
      rate_b_tick <= 1'b0;
    end else if (rate_b_cnt_q + 24'h000001 >= rate_b_div_q) begin
      rate_b_cnt_q <= '0;
      rate_b_tick <= 1'b1;
    end else begin
      rate_b_cnt_q <= rate_b_cnt_q + 24'h000001;
      rate_b_tick <= 1'b0;
    end
  end

  assign fast_sample = ctrl_q[BIT_FAST_SAMPLE];

  // ************************************************************
  // multiboard link
  // ************************************************************
  // master drives the shared lines; slaves follow combinationally,
  // so the copy adds only gate delay, well under one clock
  assign link_clk_oe = ctrl_q[BIT_CLK_MASTER];
  assign link_trig_oe = ctrl_q[BIT_TRIG_MASTER];
  assign link_clk_out = local_clk;
  assign link_trig_out = local_trig;
  assign sample_clk = ctrl_q[BIT_CLK_MASTER] ? local_clk
                                             : link_clk_in;
  assign sample_trig = ctrl_q[BIT_TRIG_MASTER] ? local_trig
                                               : link_trig_in;
  assign out_clk = oclk_master ? local_oclk : link_oclk_in;

  // ************************************************************
  // control word and calibration
  // ************************************************************
  // writable control bits; start bit self clears at finish
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[7:0] & 8'h3F;
        if (cal_finish) begin
          ctrl_q[BIT_CAL_START] <= 1'b0; // finish wins, no rerun
        end else if (cal_busy) begin
          ctrl_q[BIT_CAL_START] <= 1'b1; // keep run flag while busy
        end
      end else if (cal_finish) begin
        ctrl_q[BIT_CAL_START] <= 1'b0;
      end
    end
  end

  // sequencer: idle, run until engine done or timeout, done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_q <= CAL_IDLE;
      cal_cnt_q <= '0;
    end else begin
      unique case (cal_q)
        CAL_IDLE: begin
          cal_cnt_q <= '0;
          if (ctrl_q[BIT_CAL_START]) begin
            cal_q <= CAL_RUN;
          end
        end
        CAL_RUN: begin
          cal_cnt_q <= cal_cnt_q + 64'h1;
          if (cal_finish) begin
            cal_q <= CAL_DONE;
          end
        end
        CAL_DONE: begin
          cal_q <= CAL_IDLE;
        end
        default: begin
          cal_q <= CAL_IDLE;
        end
      endcase
    end
  end

  // finish on engine done, or forced at the time limit
  assign cal_finish = (cal_q == CAL_RUN) && (cal_engine_done ||
    (cal_cnt_q >= 64'(CAL_TIMEOUT - 1)));
  assign cal_busy = (cal_q == CAL_RUN);
  assign cal_run = cal_busy;

  // output swing: alternate full scale and midscale while running
  assign cal_out_full_scale = cal_busy && cal_cnt_q[10];

  // pass flag: high at reset, low after a failed or timed-out run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_ok_q <= 1'b1;
    end else if (cal_finish) begin
      cal_ok_q <= cal_engine_done && !cal_engine_fail;
    end
  end

  // ************************************************************
  // digital port
  // ************************************************************
  // values and directions; directions reset to input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_dir_q <= 6'h00;
      port_val_q <= 6'h00;
      port_rsv_q <= 2'h0;
    end else if (wr_port) begin
      port_val_q <= reg_wdata[PORT_N-1:0];
      port_rsv_q <= reg_wdata[7:6];
      port_dir_q <= reg_wdata[PORT_DIR_LSB +: PORT_N];
    end
  end

  assign port_line_oe = port_dir_q;
  assign port_line_out = port_val_q;

  // ************************************************************
  // event status
  // ************************************************************
  // gather event levels; local ones override inputs
  always_comb begin
    evt_now = '0;
    evt_now[EVT_W-1:0] = event_in;
    evt_now[EVT_CAL_DONE] = (cal_q == CAL_DONE);
    evt_now[EVT_PORT0_RISE] = port_dir_q[0] ? port_val_q[0]
                                             : port_line_in[0];
  end

  assign evt_rise = evt_now & ~evt_prev_q;

  // previous levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_prev_q <= '0;
    end else begin
      evt_prev_q <= evt_now;
    end
  end

  // selection and sticky response; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= '0;
      resp_q <= '0;
    end else begin
      if (wr_evt) begin
        sel_q <= reg_wdata[EVT_N-1:0];
        resp_q <= (resp_q & reg_wdata[EVT_RESP_LSB +: EVT_N]
                  & reg_wdata[EVT_N-1:0])
                  | (evt_rise & sel_q);
      end else begin
        resp_q <= resp_q | (evt_rise & sel_q);
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // registered read; unmapped addresses return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_BOARD_CONTROL: begin
          reg_rdata <= {24'h000000, 1'b0, cal_ok_q, ctrl_q[5:0]};
        end
        OFS_PORT: begin
          reg_rdata <= {18'h00000, port_dir_q, port_rsv_q,
                        port_line_in & ~port_dir_q
                        | port_val_q & port_dir_q};
        end
        OFS_RATE_A: begin
          reg_rdata <= {8'h00, rate_a_div_q};
        end
        OFS_RATE_B: begin
          reg_rdata <= {8'h00, rate_b_div_q};
        end
        OFS_EVENT_STATUS: begin
          reg_rdata <= {resp_q, cal_busy, sel_q[14:0]};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule

// *** test/aux_asserts.sv ***
`timescale 1ns/1ps
// ****************************
// port-level checks
// ****************************
module aux_asserts
  import aux_ctrl_pkg::*;
#(
  parameter longint CAL_TIMEOUT = 100 // calibration cutoff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rate_a_tick,
  input wire logic sample_clk,
  input wire logic local_clk,
  input wire logic link_clk_in,
  input wire logic link_clk_oe,
  input wire logic [5:0] port_line_out,
  input wire logic [5:0] port_line_oe,
  input wire logic cal_run
);
  localparam int CAL_MAX = int'(CAL_TIMEOUT) + 4; // slack for entry
  logic en_q; // mirror of the sample divider enable
  logic wr_ctl; // control word write
  logic wr_port; // port register write
  assign wr_ctl = reg_wr && reg_addr == OFS_BOARD_CONTROL;
  assign wr_port = reg_wr && reg_addr == OFS_PORT;
  // track enable so idle ticks can be caught
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (wr_ctl) begin
      en_q <= reg_wdata[BIT_RATE_A_EN];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_clk_follow_sel: assert property (
    sample_clk == (link_clk_oe ? local_clk : link_clk_in))
    else $error("sample clock source wrong");
  a_reset_slave_in: assert property (
    $fell(rst) |-> !link_clk_oe && port_line_oe == 6'h00)
    else $error("drivers enabled after reset");
  a_dir_write: assert property (
    wr_port |=> port_line_oe == $past(reg_wdata[13:8]))
    else $error("direction not applied");
  a_value_write: assert property (
    wr_port |=> port_line_out == $past(reg_wdata[5:0]))
    else $error("port value not applied");
  a_rate_upper_zero: assert property (
    reg_rd && reg_addr == OFS_RATE_A |=> reg_rdata[31:24] == 8'h00)
    else $error("divisor upper bits set");
  a_port_upper_zero: assert property (
    reg_rd && reg_addr == OFS_PORT |=> reg_rdata[31:14] == 18'h00000)
    else $error("port upper bits set");
  a_rate_idle: assert property (
    !en_q && !$past(en_q) |-> !rate_a_tick)
    else $error("tick while disabled");
  a_cal_start: assert property (
    wr_ctl && reg_wdata[BIT_CAL_START] && !cal_run |-> ##[1:2] cal_run)
    else $error("calibration did not start");
  a_cal_bounded: assert property (
    $rose(cal_run) |-> ##[1:CAL_MAX] !cal_run)
    else $error("calibration too long");
  c_tick: cover property (rate_a_tick);
  c_cal: cover property ($rose(cal_run));
  c_port: cover property (wr_port);
endmodule
bind board_aux_control_status aux_asserts #(.CAL_TIMEOUT(CAL_TIMEOUT)) u_chk (
  .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .rate_a_tick, .sample_clk, .local_clk, .link_clk_in, .link_clk_oe,
  .port_line_out, .port_line_oe, .cal_run);

// *** test/host_bus.sv ***
`timescale 1ns/1ps
// ****************************
// host register access model
// ****************************
module host_bus (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [31:0] reg_wdata,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 32'h00000000;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read strobe, data taken once the registered answer stands
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1 q = reg_rdata;
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
// ****************************
// bench top
// ****************************
module tb_top;
  import aux_ctrl_pkg::*;
  localparam longint CAL_TO = 100; // short calibration cutoff
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd;
  logic [31:0] reg_wdata, reg_rdata;
  logic rate_a_tick, rate_b_tick, fast_sample, cal_out_full_scale;
  logic link_clk_in = 1'b0, link_trig_in = 1'b0, link_oclk_in = 1'b0;
  logic local_clk = 1'b0, local_trig = 1'b0, local_oclk = 1'b0;
  logic sample_clk, sample_trig, link_clk_out, link_clk_oe;
  logic link_trig_out, link_trig_oe, out_clk, cal_run;
  logic oclk_master = 1'b0;
  logic cal_engine_done = 1'b0, cal_engine_fail = 1'b0;
  logic [5:0] port_line_in, port_line_out, port_line_oe;
  logic [5:0] ext = 6'h00; // far-end drive of the port pins
  logic [15:0] event_in = 16'h0000;
  logic [5:0] lk; // link signals packed for comparison
  int checks = 0;
  int n_mismatch = 0;
  // pin level: design drives where enabled, far end elsewhere
  assign port_line_in = (port_line_oe & port_line_out) | (~port_line_oe & ext);
  assign lk = {sample_clk, sample_trig, link_clk_oe, link_trig_oe,
               link_clk_out, out_clk};
  always #25 clk = ~clk;
  host_bus u_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata);
  board_aux_control_status #(.CAL_TIMEOUT(CAL_TO)) u_dut (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .rate_a_tick, .rate_b_tick, .fast_sample, .link_clk_in, .link_trig_in,
    .link_oclk_in, .local_clk, .local_trig, .local_oclk, .sample_clk,
    .sample_trig, .link_clk_out, .link_clk_oe, .link_trig_out,
    .link_trig_oe, .oclk_master, .out_clk, .port_line_in, .port_line_out,
    .port_line_oe, .cal_run, .cal_engine_done, .cal_engine_fail,
    .cal_out_full_scale, .event_in);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.rd(a, q);
    chk(q, e);
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // edges between two ticks of one divider
  task automatic gap(input logic b, input int e);
    int n;
    n = 0;
    while ((b ? rate_b_tick : rate_a_tick) !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while ((b ? rate_b_tick : rate_a_tick) !== 1'b1 && n < 200);
    chk(32'(n), 32'(e));
  endtask
  task automatic eng(input logic f);
    @(posedge clk);
    cal_engine_done <= 1'b1;
    cal_engine_fail <= f;
    @(posedge clk);
    cal_engine_done <= 1'b0;
    cal_engine_fail <= ~f;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset;
    rc(OFS_BOARD_CONTROL, 32'h00000040);
    rc(OFS_RATE_A, {8'h00, RATE_A_RST});
    rc(OFS_RATE_B, {8'h00, RATE_B_RST});
    rc(OFS_PORT, 32'h00000000);
    rc(8'h3C, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic t_rate;
    int n;
    u_host.wr(OFS_RATE_A, 32'hFF00002D);
    rc(OFS_RATE_A, 32'h0000002D);
    u_host.wr(OFS_RATE_B, 32'h00000003);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000001);
    gap(1'b0, 45);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000000);
    repeat (3) step();
    n = 0;
    repeat (100) begin
      step();
      if (rate_a_tick !== 1'b0) n++;
    end
    chk(32'(n), 32'h00000000);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000006);
    step();
    chk({31'h0, fast_sample}, 32'h00000001);
    gap(1'b1, 3);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000000);
    $display("rate test done");
  endtask
  task automatic t_link;
    @(posedge clk);
    link_clk_in <= 1'b1;
    link_trig_in <= 1'b1;
    link_oclk_in <= 1'b1;
    step();
    chk({26'h0, lk}, 32'h00000031);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000018);
    oclk_master <= 1'b1;
    step();
    chk({26'h0, lk}, 32'h0000000C);
    local_clk <= 1'b1;
    local_trig <= 1'b1;
    step();
    chk({26'h0, lk}, 32'h0000003E);
    chk({31'h0, link_trig_out}, 32'h00000001);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000000);
    oclk_master <= 1'b0;
    $display("link test done");
  endtask
  task automatic t_port;
    u_host.wr(OFS_PORT, 32'h00003F2A);
    step();
    chk({20'h0, port_line_oe, port_line_out}, 32'h00000FEA);
    rc(OFS_PORT, 32'h00003F2A);
    ext <= 6'h15;
    u_host.wr(OFS_PORT, 32'hFFFFC0C0);
    rc(OFS_PORT, 32'h000000D5);
    $display("port test done");
  endtask
  task automatic t_cal;
    u_host.wr(OFS_EVENT_STATUS, 32'h00000001);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000020);
    rc(OFS_EVENT_STATUS, 32'h00008001);
    chk({30'h0, cal_run, cal_out_full_scale}, 32'h00000002);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000000);
    rc(OFS_BOARD_CONTROL, 32'h00000060);
    eng(1'b1);
    rc(OFS_BOARD_CONTROL, 32'h00000000);
    rc(OFS_EVENT_STATUS, 32'h00010001);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000020);
    repeat (130) step();
    chk({31'h0, cal_run}, 32'h00000000);
    rc(OFS_BOARD_CONTROL, 32'h00000000);
    u_host.wr(OFS_BOARD_CONTROL, 32'h00000020);
    eng(1'b0);
    rc(OFS_BOARD_CONTROL, 32'h00000040);
    $display("calibration test done");
  endtask
  task automatic t_event;
    ext <= 6'h00;
    u_host.wr(OFS_EVENT_STATUS, 32'h00000108);
    ext <= 6'h01;
    event_in <= 16'h0008;
    rc(OFS_EVENT_STATUS, 32'h01080108);
    ext <= 6'h00;
    event_in <= 16'h0000;
    rc(OFS_EVENT_STATUS, 32'h01080108);
    u_host.wr(OFS_EVENT_STATUS, 32'h01000108);
    rc(OFS_EVENT_STATUS, 32'h01000108);
    u_host.wr(OFS_EVENT_STATUS, 32'h01000008);
    rc(OFS_EVENT_STATUS, 32'h00000008);
    event_in <= 16'h0020;
    u_host.wr(OFS_EVENT_STATUS, 32'h00200028);
    rc(OFS_EVENT_STATUS, 32'h00000028);
    $display("event test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rate();
    t_link();
    t_port();
    t_cal();
    t_event();
    end_of_test();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
